/* scta_core.sv */
`default_nettype none
// Summary of operation
// - Arm source is free-run, external, analyzer one or two; free-run after reset.
// - Free-run acquires with no trigger synchronization: once per run, or continuously in repetitive mode.
// - External arm plus immediate mode triggers as soon as arm is asserted.
// - Analyzer arm plus immediate mode triggers as soon as that analyzer arms.
// - Edge mode triggers when selected channel crosses level on chosen slope.
// - Edge source toggles between channel one and two; channel one by default.
// - Level moves in steps of one percent of full scale.
// - A level outside the waveform gives no trigger and unsynchronized display.
// - Level is clamped to the display window and starts at its default.
// - Slope toggles between positive and negative; positive by default.
// - Auto-trigger waits about one second, then shows memory and flags timeout.
// - Without auto-trigger, wait forever, hold display, show waiting.
// - Auto-trigger is on by default and toggled by one command.
// - Single mode: run makes one acquisition, then idles until next run.
// - Repetitive mode acquires and refreshes until stop; run resumes.
// - Single run mode at power-on; run mode toggles between two choices.
// - Repetitive run starts only when analyzers are off or done.
// - Immediate mode triggers on arming without looking at channel levels.
// - Trigger mode toggles between edge and immediate; edge by default.
module scta_core #(
  parameter int TIMEOUT_CYCLES = scta_pkg::AUTO_TRIG_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic ext_arm_i,
  input wire logic [1:0] ana_arm_i,
  input wire logic [1:0] ana_enabled_i,
  input wire logic [1:0] ana_done_i,
  input wire logic comp_ch1_i,
  input wire logic comp_ch2_i,
  output logic [6:0] trig_level_o,
  output logic acquiring_o,
  output logic trig_o,
  output logic display_update_o,
  output logic timeout_o,
  output logic waiting_o
);
  import scta_pkg::*;

  // Refuse counts that the 26-bit wait counter and its expiry compare cannot hold.
  if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES > (1 << 26))
  begin : g_bad_timeout
    $error("TIMEOUT_CYCLES out of range");
  end

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    scta_arm_t arm_src;
    logic imm;
    logic src2;
    logic neg;
    logic autot;
    logic rep;
    logic [6:0] level;
    scta_state_t st;
    logic [25:0] cnt;
    logic [1:0] ext_sy;
    logic [1:0] c1_sy;
    logic [1:0] c2_sy;
    logic c1_prev;
    logic c2_prev;
    logic timeout;
    logic waiting;
    logic trig;
    logic disp;
    logic triggered;
    logic blocked;
    logic acq;
  } scta_regs_t;

  scta_regs_t s;
  scta_regs_t next_s;

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode; a write acts only in the single cycle before ack rises.
  logic req;
  logic wr;
  logic [31:0] wd;
  logic cmd_wr;
  logic run_cmd;
  logic stop_cmd;
  logic ana_ready;
  logic arm_ok;
  logic ch_now;
  logic ch_prev;
  logic hit;
  logic [25:0] to_last;

  assign req = cyc_i && stb_i && !s.ack;
  assign wr = req && we_i;
  assign wd = dat_i & {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign cmd_wr = wr && (adr_i == CMD_OFS);
  assign run_cmd = cmd_wr && wd[CMD_RUN];
  assign stop_cmd = cmd_wr && wd[CMD_STOP];
  assign to_last = 26'(TIMEOUT_CYCLES - 1);

  assign ana_ready = &(~ana_enabled_i | ana_done_i);

  // Arm qualification by source; free-run never waits for an arm.
  always_comb
  begin
    unique case (s.arm_src)
      ARM_FREE: arm_ok = 1'b1;
      ARM_EXT: arm_ok = s.ext_sy[1];
      ARM_ANA1: arm_ok = ana_arm_i[0];
      ARM_ANA2: arm_ok = ana_arm_i[1];
    endcase
  end

  // edge from samples
  // Only the second synchroniser stage and its delayed copy are compared.
  assign ch_now = s.src2 ? s.c2_sy[1] : s.c1_sy[1];
  assign ch_prev = s.src2 ? s.c2_prev : s.c1_prev;
  assign hit = s.neg ? (ch_prev && !ch_now) : (!ch_prev && ch_now);

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic for every register of the block.
  always_comb
  begin
    next_s = s;
    next_s.ack = req;
    next_s.trig = 1'b0;
    next_s.disp = (s.st == ST_SHOW);
    next_s.ext_sy = {s.ext_sy[0], ext_arm_i};
    next_s.c1_sy = {s.c1_sy[0], comp_ch1_i};
    next_s.c2_sy = {s.c2_sy[0], comp_ch2_i};
    next_s.c1_prev = s.c1_sy[1];
    next_s.c2_prev = s.c2_sy[1];

    // Register reads; unmapped offsets answer with zero.
    next_s.rdat = 32'h0;
    if (req && !we_i)
    begin
      unique case (adr_i)
        CTRL_OFS: next_s.rdat = {25'h0, s.rep, s.autot, s.neg, s.src2, s.imm, s.arm_src};
        LEVEL_OFS: next_s.rdat = {25'h0, s.level};
        STAT_OFS: next_s.rdat = {26'h0, s.blocked, s.triggered, s.waiting, s.timeout, s.st};
        default: next_s.rdat = 32'h0;
      endcase
    end

    if (wr && adr_i == CTRL_OFS)
    begin
      next_s.arm_src = scta_arm_t'(wd[CTRL_ARM_LSB +: 2]);
      next_s.imm = wd[CTRL_IMM];
      next_s.src2 = wd[CTRL_SRC2];
      next_s.neg = wd[CTRL_NEG];
      next_s.autot = wd[CTRL_AUTO];
      next_s.rep = wd[CTRL_REP];
    end
    if (wr && adr_i == LEVEL_OFS)
      next_s.level = (wd[6:0] > LEVEL_MAX || wd[31:7] != 25'h0) ? LEVEL_MAX : wd[6:0];
    if (cmd_wr)
    begin
      next_s.imm = s.imm ^ wd[CMD_TGL_IMM];
      next_s.src2 = s.src2 ^ wd[CMD_TGL_SRC];
      next_s.neg = s.neg ^ wd[CMD_TGL_SLOPE];
      next_s.autot = s.autot ^ wd[CMD_TGL_AUTO];
      next_s.rep = s.rep ^ wd[CMD_TGL_REP];
      if (wd[CMD_LVL_UP] && !wd[CMD_LVL_DN] && s.level < LEVEL_MAX)
        next_s.level = s.level + 7'h01;
      else if (wd[CMD_LVL_DN] && !wd[CMD_LVL_UP] && s.level != 7'h00)
        next_s.level = s.level - 7'h01;
    end

    // Run sequencer; stop always wins the next state, but a trig pulse or timeout flag set in that cycle still appears.
    unique case (s.st)
      ST_IDLE:
      begin
        if (run_cmd && !stop_cmd && s.rep && !ana_ready)
          next_s.blocked = 1'b1;
        else if (run_cmd && !stop_cmd)
        begin
          next_s.st = ST_ARM;
          next_s.timeout = 1'b0;
          next_s.blocked = 1'b0;
          next_s.triggered = 1'b0;
        end
      end
      ST_ARM:
      begin
        if (s.arm_src == ARM_FREE)
        begin
          next_s.st = ST_SHOW;
          next_s.triggered = 1'b0;
        end
        else if (arm_ok && s.imm)
        begin
          next_s.st = ST_SHOW;
          next_s.trig = 1'b1;
          next_s.triggered = 1'b1;
        end
        else if (arm_ok)
        begin
          next_s.st = ST_WAIT;
          next_s.cnt = 26'h0;
        end
      end
      ST_WAIT:
      begin
        // edge trigger
        // A level beyond the waveform never toggles the comparator, so no hit.
        if (hit)
        begin
          next_s.st = ST_SHOW;
          next_s.trig = 1'b1;
          next_s.triggered = 1'b1;
        end
        else if (s.autot && s.cnt >= to_last)
        begin
          next_s.st = ST_SHOW;
          next_s.timeout = 1'b1;
          next_s.triggered = 1'b0;
        end
        else if (s.cnt < to_last)
          next_s.cnt = s.cnt + 26'h1;
      end
      ST_SHOW:
      begin
        next_s.st = s.rep ? ST_ARM : ST_IDLE;
      end
    endcase
    if (stop_cmd)
      next_s.st = ST_IDLE;
    next_s.waiting = (next_s.st == ST_WAIT) && !next_s.autot;
    // Busy flag follows the next state, so the output leaves a flop with no decode delay.
    next_s.acq = (next_s.st != ST_IDLE);
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register with synchronous reset to the power-on settings.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= '0;
      s.arm_src <= ARM_FREE;
      s.imm <= RST_IMM;
      s.src2 <= RST_SRC2;
      s.neg <= RST_NEG;
      s.autot <= RST_AUTO;
      s.rep <= RST_REP;
      s.level <= RST_LEVEL;
      s.st <= ST_IDLE;
    end
    else
      s <= next_s;
  end

  // Outputs come straight from the state flops.
  assign dat_o = s.rdat;
  assign ack_o = s.ack;
  assign trig_level_o = s.level;
  assign acquiring_o = s.acq;
  assign trig_o = s.trig;
  assign display_update_o = s.disp;
  assign timeout_o = s.timeout;
  assign waiting_o = s.waiting;

  //////////////////////////////////////////////////////////////////////////////
  // Checks on the sequencer.
  a_reset_defaults: assert property (@(posedge clk_i) $fell(rst_i) |->
    s.arm_src == ARM_FREE && !s.src2 && !s.neg && s.autot && !s.rep && !s.imm && s.level == RST_LEVEL)
    else $error("defaults wrong after reset");
  a_free_run: assert property (@(posedge clk_i) disable iff (rst_i)
    s.st == ST_ARM && s.arm_src == ARM_FREE && !stop_cmd |=> s.st == ST_SHOW && !trig_o ##1 display_update_o)
    else $error("free-run did not present unsynchronized");
  a_ext_immediate: assert property (@(posedge clk_i) disable iff (rst_i)
    s.st == ST_ARM && s.arm_src == ARM_EXT && s.imm && s.ext_sy[1] && !stop_cmd |=> trig_o)
    else $error("external arm did not trigger");
  a_ana_immediate: assert property (@(posedge clk_i) disable iff (rst_i)
    s.st == ST_ARM && s.arm_src == ARM_ANA2 && s.imm && ana_arm_i[1] && !stop_cmd |=> trig_o && s.triggered)
    else $error("analyzer arm did not trigger");
  a_edge_fires: assert property (@(posedge clk_i) disable iff (rst_i)
    s.st == ST_WAIT && hit && !stop_cmd |=> trig_o ##1 display_update_o)
    else $error("edge did not trigger");
  a_level_clamp: assert property (@(posedge clk_i) disable iff (rst_i)
    trig_level_o <= LEVEL_MAX)
    else $error("level outside window");
  a_timeout_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    s.st == ST_WAIT && s.autot && s.cnt == to_last && !hit && !stop_cmd |=> timeout_o && !trig_o && s.st == ST_SHOW)
    else $error("timeout not taken");
  a_hold_waiting: assert property (@(posedge clk_i) disable iff (rst_i)
    s.st == ST_WAIT && !s.autot && !hit && !stop_cmd && !cmd_wr |=> s.st == ST_WAIT && waiting_o && !display_update_o)
    else $error("left wait without trigger");
  a_single_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    s.st == ST_SHOW && !s.rep |=> s.st == ST_IDLE && display_update_o)
    else $error("single run did not idle");
  a_repeat_rearm: assert property (@(posedge clk_i) disable iff (rst_i)
    s.st == ST_SHOW && s.rep && !stop_cmd |=> s.st == ST_ARM)
    else $error("repetitive run did not rearm");
  a_rep_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    s.st == ST_IDLE && run_cmd && s.rep && !ana_ready |=> s.st == ST_IDLE && s.blocked)
    else $error("repetitive run started while analyzer busy");
  a_count_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    s.st == ST_ARM && s.arm_src != ARM_FREE && arm_ok && !s.imm && !stop_cmd |=> s.st == ST_WAIT && s.cnt == 26'h0)
    else $error("timeout counter not cleared at arm");

endmodule // scta_core
`default_nettype wire

/* scta_far.sv */
`default_nettype none
// Far side: front-panel arm pin, two analyzers and the two channel comparators.
module scta_far (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ext_req_i,
  input wire logic [1:0] ana_req_i,
  input wire logic [1:0] ana_en_i,
  input wire logic [1:0] ana_fin_i,
  input wire logic ch1_req_i,
  input wire logic ch2_req_i,
  output logic ext_arm_o,
  output logic [1:0] ana_arm_o,
  output logic [1:0] ana_en_o,
  output logic [1:0] ana_done_o,
  output logic comp_ch1_o,
  output logic comp_ch2_o
);
  timeunit 1ns;
  timeprecision 1ns;

  //////////////////////////////////////////////////////////////////////////////
  // All levels change just after the clock edge, like real parts on this clock.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ext_arm_o <= 1'b0;
      ana_arm_o <= 2'b00;
      ana_en_o <= 2'b00;
      ana_done_o <= 2'b00;
    end
    else
    begin
      ext_arm_o <= ext_req_i;
      ana_arm_o <= ana_req_i;
      ana_en_o <= ana_en_i;
      // analyzer done flags
      // A disabled analyzer never reports done, so done alone cannot unblock a run.
      ana_done_o <= ana_en_i & ana_fin_i;
    end
    comp_ch1_o <= ch1_req_i;
    comp_ch2_o <= ch2_req_i;
  end
endmodule // scta_far
`default_nettype wire

/* scta_pkg.sv */
`default_nettype none
package scta_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the bus.
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] LEVEL_OFS = 4'h4;
  localparam logic [3:0] CMD_OFS = 4'h8;
  localparam logic [3:0] STAT_OFS = 4'hc;

  // Control register field positions.
  localparam int CTRL_ARM_LSB = 0;
  localparam int CTRL_IMM = 2;
  localparam int CTRL_SRC2 = 3;
  localparam int CTRL_NEG = 4;
  localparam int CTRL_AUTO = 5;
  localparam int CTRL_REP = 6;

  // Command register bit positions; every bit is a self-clearing action.
  localparam int CMD_RUN = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_TGL_IMM = 2;
  localparam int CMD_TGL_SRC = 3;
  localparam int CMD_TGL_SLOPE = 4;
  localparam int CMD_TGL_AUTO = 5;
  localparam int CMD_TGL_REP = 6;
  localparam int CMD_LVL_UP = 7;
  localparam int CMD_LVL_DN = 8;

  // Status register bit positions.
  localparam int STAT_ST_LSB = 0;
  localparam int STAT_TIMEOUT = 2;
  localparam int STAT_WAITING = 3;
  localparam int STAT_TRIGGERED = 4;
  localparam int STAT_BLOCKED = 5;

  // Values after reset.
  localparam logic RST_IMM = 1'b0;
  localparam logic RST_SRC2 = 1'b0;
  localparam logic RST_NEG = 1'b0;
  localparam logic RST_AUTO = 1'b1;
  localparam logic RST_REP = 1'b0;

  // Level is a percentage of the display window; one step is 1 % of full scale.
  localparam logic [6:0] LEVEL_MAX = 7'h64;
  localparam logic [6:0] RST_LEVEL = 7'h32;

  // Auto-trigger wait: time in milliseconds and the clock rate give the count.
  localparam int CLK_HZ = 50000000;
  localparam int AUTO_TRIG_MS = 1000;
  localparam int AUTO_TRIG_CYCLES = AUTO_TRIG_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {
    ARM_FREE = 2'b00,
    ARM_EXT = 2'b01,
    ARM_ANA1 = 2'b10,
    ARM_ANA2 = 2'b11
  } scta_arm_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARM = 2'b01,
    ST_WAIT = 2'b10,
    ST_SHOW = 2'b11
  } scta_state_t;

endpackage
`default_nettype wire

/* tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import scta_pkg::*;

  localparam int TO = 40;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rd;
  logic [31:0] dat_o;
  logic ack_o, trig_o, disp, tmo, wtg, acq;
  logic [6:0] lvl;
  logic ext_q = 1'b0;
  logic c1_q = 1'b0;
  logic c2_q = 1'b1;
  logic [1:0] an_q = 2'b00;
  logic [1:0] en_q = 2'b00;
  logic [1:0] fin_q = 2'b00;
  wire logic ext, c1, c2;
  wire logic [1:0] an, en, dn;
  wire logic [3:0] obs = {wtg, tmo, disp, trig_o};
  logic [3:0] h;
  int n;
  int mismatches = 0;
  int total_checks = 0;

  //////////////////////////////////////////////////////////////////////////////
  // Clock of 50 MHz.
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end

  scta_core #(.TIMEOUT_CYCLES(TO)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .ext_arm_i(ext),
    .ana_arm_i(an), .ana_enabled_i(en), .ana_done_i(dn), .comp_ch1_i(c1), .comp_ch2_i(c2),
    .trig_level_o(lvl), .acquiring_o(acq), .trig_o(trig_o), .display_update_o(disp),
    .timeout_o(tmo), .waiting_o(wtg));

  scta_far far (.clk_i(clk_i), .rst_i(rst_i), .ext_req_i(ext_q), .ana_req_i(an_q), .ana_en_i(en_q),
    .ana_fin_i(fin_q), .ch1_req_i(c1_q), .ch2_req_i(c2_q), .ext_arm_o(ext), .ana_arm_o(an),
    .ana_en_o(en), .ana_done_o(dn), .comp_ch1_o(c1), .comp_ch2_o(c2));

  //////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run; also reached when a bounded wait runs out.
  task stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Word and flag comparisons.
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task chk1(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask

  // One classic cycle; request held until ack is sampled high, then released.
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hf};
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack_o !== 1'b1 && k < 20);
    rd = dat_o;
    {cyc, stb, we} <= 3'b000;
    if (ack_o !== 1'b1)
    begin
      mismatches++;
      stop_test();
    end
  endtask

  task wr(input logic [3:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task rc(input string nm, input logic [3:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  // Waits for obs[k]; collects every event seen meanwhile in h.
  task run_to(input int k, input int lim, input bit must);
    h = 4'h0;
    n = 0;
    do
    begin
      @(posedge clk_i);
      h = h | obs;
      n++;
    end
    while (obs[k] !== 1'b1 && n < lim);
    if (must && obs[k] !== 1'b1)
    begin
      mismatches++;
      stop_test();
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence; every mode is set at least once.
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rc("ctrl", CTRL_OFS, 32'h20);
    rc("level", LEVEL_OFS, 32'h32);
    rc("unmapped", 4'h2, 32'h0);
    wr(CMD_OFS, 32'h7c);
    rc("ctrl", CTRL_OFS, 32'h5c);
    wr(CMD_OFS, 32'h7c);
    rc("ctrl", CTRL_OFS, 32'h20);
    wr(LEVEL_OFS, 32'hff);
    rc("level", LEVEL_OFS, 32'h64);
    wr(CMD_OFS, 32'h80);
    rc("level", LEVEL_OFS, 32'h64);
    wr(CMD_OFS, 32'h100);
    rc("level", LEVEL_OFS, 32'h63);
    chk("trig_level", 32'h63, {25'h0, lvl});
    // Free-run ignores the trigger.
    wr(CMD_OFS, 32'h1);
    run_to(1, 50, 1);
    chk1("trig", 1'b0, h[0]);
    rc("stat", STAT_OFS, 32'h0);
    // Immediate mode, external arm, then analyzer two.
    wr(CTRL_OFS, 32'h25);
    ext_q <= 1'b1;
    wr(CMD_OFS, 32'h1);
    run_to(1, 50, 1);
    chk1("trig", 1'b1, h[0]);
    rc("stat", STAT_OFS, 32'h10);
    ext_q <= 1'b0;
    wr(CTRL_OFS, 32'h27);
    an_q <= 2'b10;
    wr(CMD_OFS, 32'h1);
    run_to(1, 50, 1);
    chk1("trig", 1'b1, h[0]);
    an_q <= 2'b00;
    // Immediate mode arm_source_select analyzer one.
    wr(CTRL_OFS, 32'h26);
    an_q <= 2'b01;
    wr(CMD_OFS, 32'h1);
    run_to(1, 50, 1);
    chk1("trig", 1'b1, h[0]);
    rc("stat", STAT_OFS, 32'h10);
    an_q <= 2'b00;
    // Edge mode: channel one rising, then channel two falling.
    wr(CTRL_OFS, 32'h21);
    ext_q <= 1'b1;
    wr(CMD_OFS, 32'h1);
    repeat (6) @(posedge clk_i);
    c1_q <= 1'b1;
    run_to(0, 30, 1);
    chk1("timeout", 1'b0, h[2]);
    wr(CTRL_OFS, 32'h39);
    wr(CMD_OFS, 32'h1);
    repeat (6) @(posedge clk_i);
    c2_q <= 1'b0;
    run_to(0, 30, 1);
    chk1("timeout", 1'b0, h[2]);
    // Level above the waveform: no edge ever comes, auto-trigger expires.
    wr(CTRL_OFS, 32'h21);
    wr(CMD_OFS, 32'h1);
    run_to(1, 200, 1);
    chk1("trig", 1'b0, h[0]);
    chk1("timeout", 1'b1, tmo);
    chk1("span", 1'b1, n >= TO);
    rc("stat", STAT_OFS, 32'h04);
    // Auto-trigger off: waits with the display held.
    wr(CTRL_OFS, 32'h01);
    wr(CMD_OFS, 32'h1);
    run_to(3, 50, 1);
    chk1("timeout", 1'b0, tmo);
    run_to(1, 3 * TO, 0);
    chk1("display", 1'b0, h[1]);
    chk1("waiting", 1'b1, wtg);
    wr(CMD_OFS, 32'h2);
    repeat (2) @(posedge clk_i);
    chk1("waiting", 1'b0, wtg);
    // Repetitive run refused while an enabled analyzer is not done.
    en_q <= 2'b01;
    wr(CTRL_OFS, 32'h60);
    wr(CMD_OFS, 32'h1);
    wb(1'b0, STAT_OFS, 32'h0);
    chk("blocked", 32'h20, rd & 32'h23);
    chk1("acquiring", 1'b0, acq);
    fin_q <= 2'b01;
    repeat (2) @(posedge clk_i);
    wr(CMD_OFS, 32'h1);
    run_to(1, 50, 1);
    run_to(1, 50, 1);
    chk1("acquiring", 1'b1, acq);
    wr(CMD_OFS, 32'h2);
    repeat (2) @(posedge clk_i);
    chk1("acquiring", 1'b0, acq);
    wr(CMD_OFS, 32'h1);
    run_to(1, 50, 1);
    chk1("acquiring", 1'b1, acq);
    wr(CMD_OFS, 32'h2);
    stop_test();
  end
endmodule // tb
`default_nettype wire
